// ---- core/swc_sleep_wake.sv ----
/*
  Sleep/wake sequencer of a small microcontroller with its register file.
  Assumes: a processor core on aclk that pulses sleep_exec, holds its state
  while cpu clock enable is low, and honours resume/vector; pin-level reset,
  watchdog and low-frequency tick inputs are asynchronous to aclk.
*/
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Sleep is entered only by the core's sleep instruction pulse.
// - Entering sleep clears the watchdog; it keeps counting if enabled in sleep.
// - Entering sleep clears the powerdown flag and sets the timeout flag.
// - CPU clock stops in sleep; low-frequency oscillator keeps running.
// - 16-bit timer runs in sleep when clocked from low-frequency osc or pin.
// - Converter runs on in sleep when its dedicated oscillator is selected.
// - I/O pins hold their pre-sleep drive state while asleep.
// - Non-watchdog resets act the same asleep as awake.
// - Pin, brown-out, power-on reset; watchdog and interrupts resume execution.
// - Next instruction is prefetched while the sleep instruction executes.
// - Only enabled interrupts wake, regardless of global enable.
// - After wake run next instruction, then vector if global enable set and the wake was not by watchdog.
// - Watchdog is cleared on every wake-up, whatever the source.
// - Pending enabled interrupt with global enable off makes sleep a no-op.
// - Interrupt during sleep execution completes sleep, then wakes at once.
// - Crystal modes wait 1024 oscillator periods on wake; others do not.
// - Regulator power-mode bit puts regulator in low power while asleep.
// - Waking from low-power sleep adds a regulator settle delay.
// - Peripherals unfit for low-power sleep keep regulator in normal mode.
// - High-frequency osc may stay on in sleep when cells need it.
// - Unregulated variant always sleeps lowest power with no added delay.
// - Third flag register sets cell flags on events; bits 7-2 read zero.
// - Regulator mode is bit 1, resets 0; bit 0 reserved, reads one.
// - Watchdog timeout in sleep wakes and updates timeout/powerdown flags.
module swc_sleep_wake
  import swc_pkg::*;
#(
  parameter int N_EXT_SRC = 8,
  parameter bit UNREGULATED = 1'b0,
  parameter int OST_CYCLES = SWC_OST_CYCLES,
  parameter int REG_SETTLE_CYCLES = SWC_REG_SETTLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  input wire logic global_irq_enable,
  input wire logic [N_EXT_SRC-1:0] ext_irq_pending,
  input wire logic logic_cell1_event,
  input wire logic logic_cell2_event,
  input wire logic lp_unfit_periph_en,
  input wire logic low_freq_tick,
  input wire logic watchdog_timeout,
  input wire logic external_reset_pin_n,
  input wire logic brownout_reset,
  input wire logic power_on_reset,
  output logic device_reset_req,
  output logic watchdog_clear,
  output logic prefetch_next,
  output logic sleep_nop_done,
  output logic resume_exec,
  output logic vector_to_isr,
  output swc_power_s power_ctl,
  output logic timeout_flag,
  output logic powerdown_flag
);

  // =========================================================
  // Input synchronisers
  localparam int N_SYNC = N_EXT_SRC + 5;
  logic [N_SYNC-1:0] sync_a;
  logic [N_SYNC-1:0] sync_b;
  logic tick_d;
  logic wdt_d;
  logic [N_EXT_SRC-1:0] ext_pend;
  logic tick_pulse;
  logic wdt_pulse;
  logic rst_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {ext_irq_pending, low_freq_tick, watchdog_timeout,
                 ~external_reset_pin_n, brownout_reset, power_on_reset};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_d <= 1'b0;
      wdt_d <= 1'b0;
    end else begin
      tick_d <= sync_b[4];
      wdt_d <= sync_b[3];
    end
  end

  assign ext_pend = sync_b[N_SYNC-1:5];
  assign tick_pulse = sync_b[4] & ~tick_d;
  assign wdt_pulse = sync_b[3] & ~wdt_d;
  // Reset sources pass through in every state alike
  assign rst_any = |sync_b[2:0];
  assign device_reset_req = rst_any;

  // =========================================================
  // Registers
  logic [1:0] flags3;
  logic [1:0] enable3;
  logic reg_pm;
  swc_slpcfg_s slpcfg;
  swc_state_e state;
  swc_state_e next_state;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic wr_flags3;
  logic [1:0] cell_evt;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == SWC_OFF_FLAGS3) || (a == SWC_OFF_ENABLE3) || (a == SWC_OFF_REGCTL) ||
                  (a == SWC_OFF_STATUS) || (a == SWC_OFF_SLPCFG);
  endfunction : addr_mapped

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = wr_fire && addr_mapped(aw_addr) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SWC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr) ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Event set beats a software clear in the same cycle
  assign cell_evt = {logic_cell2_event, logic_cell1_event};
  assign wr_flags3 = wr_ok && (aw_addr == SWC_OFF_FLAGS3);

  generate
    for (genvar i = 0; i < 2; i++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags3[i] <= SWC_RST_FLAGS3[i];
        end else if (cell_evt[i]) begin
          flags3[i] <= 1'b1;
        end else if (wr_flags3) begin
          flags3[i] <= w_data[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable3 <= SWC_RST_ENABLE3;
      reg_pm <= SWC_RST_REG_PM;
      slpcfg <= swc_slpcfg_s'({SWC_RST_OSC_MODE, SWC_RST_SLPCFG[4:0]});
    end else if (wr_ok) begin
      if (aw_addr == SWC_OFF_ENABLE3) begin
        enable3 <= w_data[SWC_BIT_CELL2:SWC_BIT_CELL1];
      end
      // Unregulated part has no selectable low-power mode
      if (aw_addr == SWC_OFF_REGCTL) begin
        reg_pm <= w_data[SWC_BIT_REG_PM] & !UNREGULATED;
      end
      if (aw_addr == SWC_OFF_SLPCFG && w_strb[1]) begin
        slpcfg <= swc_slpcfg_s'({w_data[SWC_BIT_OSC_MODE +: 3], w_data[4:0]});
      end
    end
  end

  // =========================================================
  // Read channel
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      SWC_OFF_FLAGS3: rd_word[1:0] = flags3;
      SWC_OFF_ENABLE3: rd_word[1:0] = enable3;
      SWC_OFF_REGCTL: begin
        rd_word[SWC_BIT_REG_PM] = reg_pm;
        rd_word[SWC_BIT_REG_RSVD] = SWC_RST_REG_RSVD;
      end
      SWC_OFF_STATUS: begin
        rd_word[SWC_BIT_TO] = timeout_flag;
        rd_word[SWC_BIT_PD] = powerdown_flag;
        rd_word[SWC_BIT_STATE +: 3] = state;
      end
      SWC_OFF_SLPCFG: begin
        rd_word[4:0] = slpcfg[4:0];
        rd_word[SWC_BIT_OSC_MODE +: 3] = slpcfg.osc_mode;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SWC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =========================================================
  // Sleep sequencer
  logic pending;
  logic low_power;
  logic crystal;
  logic [SWC_DLY_W-1:0] delay_cnt;
  logic [SWC_DLY_W-1:0] wake_delay;
  logic wake_by_wdt;

  // Enable gates each flag; global enable plays no part
  assign pending = |(enable3 & flags3) || |ext_pend;
  // Sleep-unfit peripherals veto the low-power regulator
  assign low_power = reg_pm && !lp_unfit_periph_en && !UNREGULATED;
  assign crystal = slpcfg.osc_mode inside {SWC_OSC_XTAL_LP, SWC_OSC_XTAL_XT, SWC_OSC_XTAL_HS};
  // Start-up only for crystals, settle only from low power
  assign wake_delay = SWC_DLY_W'((crystal ? OST_CYCLES : 0) + (low_power ? REG_SETTLE_CYCLES : 0));

  always_comb begin
    next_state = state;
    case (state)
      SWC_ST_AWAKE: begin
        // Pending with global enable off turns sleep into a no-op
        if (sleep_exec && (global_irq_enable || !pending)) begin
          next_state = SWC_ST_ENTER;
        end
      end
      SWC_ST_ENTER: begin
        next_state = pending ? SWC_ST_WAKE_WAIT : SWC_ST_ASLEEP;
      end
      SWC_ST_ASLEEP: begin
        // Slow tick paces interrupt sampling
        if ((tick_pulse && pending) || (wdt_pulse && slpcfg.wdt_sleep)) begin
          next_state = SWC_ST_WAKE_WAIT;
        end
      end
      SWC_ST_WAKE_WAIT: begin
        if (delay_cnt == '0) begin
          next_state = SWC_ST_RESUME;
        end
      end
      SWC_ST_RESUME: next_state = SWC_ST_AWAKE;
      default: next_state = SWC_ST_AWAKE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rst_any) begin
      state <= SWC_ST_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_cnt <= '0;
    end else if (next_state == SWC_ST_WAKE_WAIT && state != SWC_ST_WAKE_WAIT) begin
      delay_cnt <= wake_delay;
    end else if (delay_cnt != '0) begin
      delay_cnt <= delay_cnt - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_by_wdt <= 1'b0;
    end else if (state != SWC_ST_WAKE_WAIT) begin
      wake_by_wdt <= state == SWC_ST_ASLEEP && wdt_pulse && slpcfg.wdt_sleep;
    end
  end

  // Status flags: reset sets both; sleep entry PD=0, TO=1; watchdog wake TO=0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag <= SWC_RST_TO;
      powerdown_flag <= SWC_RST_PD;
    end else if (state == SWC_ST_AWAKE && next_state == SWC_ST_ENTER) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (state == SWC_ST_ASLEEP && wdt_pulse && slpcfg.wdt_sleep) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end
  end

  // Core handshake pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_clear <= 1'b0;
      prefetch_next <= 1'b0;
      sleep_nop_done <= 1'b0;
      resume_exec <= 1'b0;
      vector_to_isr <= 1'b0;
    end else begin
      // Entry and every wake clear the watchdog
      watchdog_clear <= (state == SWC_ST_AWAKE && next_state == SWC_ST_ENTER) ||
                        (state != SWC_ST_WAKE_WAIT && next_state == SWC_ST_WAKE_WAIT);
      prefetch_next <= state == SWC_ST_AWAKE && sleep_exec && !rst_any;
      sleep_nop_done <= state == SWC_ST_AWAKE && sleep_exec && !rst_any &&
                        !global_irq_enable && pending;
      resume_exec <= state == SWC_ST_RESUME;
      // Vector only after the next instruction, and only with global enable
      vector_to_isr <= state == SWC_ST_RESUME && global_irq_enable && !wake_by_wdt;
    end
  end

  // =========================================================
  // Power controls
  logic asleep;
  assign asleep = state == SWC_ST_ASLEEP || state == SWC_ST_ENTER || state == SWC_ST_WAKE_WAIT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ctl <= '{cpu_clk_en: 1'b1, lf_osc_run: 1'b1, hf_osc_run: 1'b1, timer16_run: 1'b1,
                     adc_run: 1'b1, io_hold: 1'b0, regulator_low_power: 1'b0, wdt_run: 1'b1};
    end else begin
      power_ctl.cpu_clk_en <= !asleep;
      power_ctl.lf_osc_run <= 1'b1;
      power_ctl.hf_osc_run <= !asleep || slpcfg.hf_keep;
      power_ctl.timer16_run <= !asleep || slpcfg.t16_lf || slpcfg.t16_pin;
      power_ctl.adc_run <= !asleep || slpcfg.adc_osc;
      // Pads freeze so pin drive stays as before sleep
      power_ctl.io_hold <= asleep;
      power_ctl.regulator_low_power <= (state == SWC_ST_ASLEEP) && low_power;
      power_ctl.wdt_run <= !asleep || slpcfg.wdt_sleep;
    end
  end

endmodule : swc_sleep_wake

`default_nettype wire

// ---- common/swc_pkg.sv ----
/*
  Package for the sleep/wake controller: register map, field positions,
  reset values, timing constants, oscillator modes and the FSM states.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package swc_pkg;

  // =========================================================
  // Register map (byte addresses)
  localparam logic [7:0] SWC_OFF_FLAGS3 = 8'h00;
  localparam logic [7:0] SWC_OFF_ENABLE3 = 8'h04;
  localparam logic [7:0] SWC_OFF_REGCTL = 8'h08;
  localparam logic [7:0] SWC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] SWC_OFF_SLPCFG = 8'h10;

  // =========================================================
  // Field positions
  localparam int SWC_BIT_CELL1 = 0;
  localparam int SWC_BIT_CELL2 = 1;
  localparam int SWC_BIT_REG_RSVD = 0;
  localparam int SWC_BIT_REG_PM = 1;
  localparam int SWC_BIT_PD = 3;
  localparam int SWC_BIT_TO = 4;
  localparam int SWC_BIT_STATE = 8;
  localparam int SWC_BIT_WDT_SLEEP = 0;
  localparam int SWC_BIT_T16_LF = 1;
  localparam int SWC_BIT_T16_PIN = 2;
  localparam int SWC_BIT_ADC_OSC = 3;
  localparam int SWC_BIT_HF_KEEP = 4;
  localparam int SWC_BIT_OSC_MODE = 8;

  // =========================================================
  // Reset values
  localparam logic [1:0] SWC_RST_FLAGS3 = 2'h0;
  localparam logic [1:0] SWC_RST_ENABLE3 = 2'h0;
  localparam logic SWC_RST_REG_PM = 1'b0;
  localparam logic SWC_RST_REG_RSVD = 1'b1;
  localparam logic SWC_RST_PD = 1'b1;
  localparam logic SWC_RST_TO = 1'b1;
  localparam logic [7:0] SWC_RST_SLPCFG = 8'h00;
  localparam logic [2:0] SWC_RST_OSC_MODE = 3'h0;

  // =========================================================
  // Timing
  localparam int SWC_CLK_MHZ = 200;
  localparam int SWC_OST_OSC_PERIODS = 1024;
  localparam int SWC_OST_CYCLES = SWC_OST_OSC_PERIODS;
  localparam int SWC_REG_SETTLE_NS = 5000;
  localparam int SWC_REG_SETTLE_CYCLES = (SWC_REG_SETTLE_NS * SWC_CLK_MHZ + 999) / 1000;
  localparam int SWC_DLY_W = 16;

  // =========================================================
  // AXI answers
  localparam logic [1:0] SWC_RESP_OKAY = 2'b00;
  localparam logic [1:0] SWC_RESP_SLVERR = 2'b10;

  // =========================================================
  // Types
  typedef enum logic [2:0] {
    SWC_OSC_INTERNAL = 3'h0,
    SWC_OSC_EXTCLK = 3'h1,
    SWC_OSC_RC = 3'h2,
    SWC_OSC_XTAL_LP = 3'h3,
    SWC_OSC_XTAL_XT = 3'h4,
    SWC_OSC_XTAL_HS = 3'h5
  } swc_osc_e;

  typedef enum logic [2:0] {
    SWC_ST_AWAKE = 3'b000,
    SWC_ST_ENTER = 3'b001,
    SWC_ST_ASLEEP = 3'b011,
    SWC_ST_WAKE_WAIT = 3'b010,
    SWC_ST_RESUME = 3'b110
  } swc_state_e;

  typedef struct packed {
    logic [2:0] osc_mode;
    logic hf_keep;
    logic adc_osc;
    logic t16_pin;
    logic t16_lf;
    logic wdt_sleep;
  } swc_slpcfg_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic lf_osc_run;
    logic hf_osc_run;
    logic timer16_run;
    logic adc_run;
    logic io_hold;
    logic regulator_low_power;
    logic wdt_run;
  } swc_power_s;

endpackage : swc_pkg

// ---- sim/swc_sleep_wake_chk.sv ----
/*
  Port-level assertions for the sleep/wake sequencer.
  Assumes binding to swc_sleep_wake, one clock domain, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_sleep_wake_chk
  import swc_pkg::*;
#(
  parameter int OST_CYCLES = 4,
  parameter int REG_SETTLE_CYCLES = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_exec,
  input wire logic global_irq_enable,
  input wire logic lp_unfit_periph_en,
  input wire logic brownout_reset,
  input wire logic prefetch_next,
  input wire logic sleep_nop_done,
  input wire logic watchdog_clear,
  input wire logic resume_exec,
  input wire logic vector_to_isr,
  input wire swc_power_s power_ctl,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic device_reset_req
);
  // ==========================================
  // Cycles since last watchdog clear, saturating
  int since_clr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_clr <= 0;
    end else if (watchdog_clear) begin
      since_clr <= 0;
    end else if (since_clr < 65535) begin
      since_clr <= since_clr + 1;
    end
  end

  // ==========================================
  // Assertions
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_prefetch_cause: assert property (prefetch_next |-> $past(sleep_exec))
    else $error("prefetch without sleep instruction");
  chk_nop_keeps_flags: assert property (sleep_nop_done |->
    !watchdog_clear && $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("no-op sleep touched flags or watchdog");
  chk_enter_flags: assert property (prefetch_next && !sleep_nop_done |->
    watchdog_clear && timeout_flag && !powerdown_flag ##1 !power_ctl.cpu_clk_en)
    else $error("sleep entry flags or clock stop wrong");
  chk_sleep_only_cmd: assert property ($fell(power_ctl.cpu_clk_en) |-> $past(sleep_exec, 2))
    else $error("cpu clock stopped without sleep instruction");
  chk_lf_osc_runs: assert property (!power_ctl.cpu_clk_en |-> power_ctl.lf_osc_run)
    else $error("slow oscillator stopped in sleep");
  chk_resume_clock: assert property (resume_exec |=> power_ctl.cpu_clk_en)
    else $error("cpu clock not back after resume");
  chk_vector_gie: assert property (vector_to_isr |-> resume_exec && $past(global_irq_enable))
    else $error("vector without resume or global enable");
  chk_wake_clears_wdt: assert property (resume_exec |->
    since_clr <= OST_CYCLES + REG_SETTLE_CYCLES + 4)
    else $error("wake without watchdog clear");
  chk_regulator_normal: assert property (power_ctl.regulator_low_power |->
    !$past(lp_unfit_periph_en))
    else $error("low-power regulator with unfit peripheral");
  chk_reset_source: assert property (brownout_reset [*4] |-> device_reset_req)
    else $error("brown-out did not request reset");
endmodule : swc_sleep_wake_chk

bind swc_sleep_wake swc_sleep_wake_chk #(
  .OST_CYCLES(OST_CYCLES),
  .REG_SETTLE_CYCLES(REG_SETTLE_CYCLES)
) swc_sleep_wake_chk_inst (
  .aclk, .aresetn, .sleep_exec, .global_irq_enable, .lp_unfit_periph_en,
  .brownout_reset, .prefetch_next, .sleep_nop_done, .watchdog_clear,
  .resume_exec, .vector_to_isr, .power_ctl, .timeout_flag, .powerdown_flag,
  .device_reset_req
);
`default_nettype wire

// ---- sim/swc_core_model.sv ----
/*
  Processor core model: issues the sleep instruction and stalls.
  Assumes the sequencer's resume, no-op and reset outputs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic resume_exec,
  input wire logic sleep_nop_done,
  input wire logic device_reset_req,
  output logic sleep_exec
);
  // ==========================================
  // One sleep at a time; core stalls until it ends
  logic busy;
  always_ff @(posedge aclk) begin
    sleep_exec <= 1'b0;
    if (!aresetn || resume_exec || sleep_nop_done || device_reset_req) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      sleep_exec <= 1'b1;
      busy <= 1'b1;
    end
  end
endmodule : swc_core_model
`default_nettype wire

// ---- sim/swc_sleep_wake_test.sv ----
/*
  Self-checking bench for the sleep/wake sequencer.
  Assumes short start-up and settle counts (4 and 3) set here.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module swc_sleep_wake_test
  import swc_pkg::*;
();
  localparam int OST = 4;
  localparam int SET = 3;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic [1:0] rsp;
  } swc_row_s;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, global_irq_enable = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, ext_irq_pending = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, logic_cell1_event = 1'b0;
  logic logic_cell2_event = 1'b0, lp_unfit_periph_en = 1'b0, low_freq_tick = 1'b0;
  logic watchdog_timeout = 1'b0, external_reset_pin_n = 1'b1;
  logic brownout_reset = 1'b0, power_on_reset = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic sleep_exec, device_reset_req, watchdog_clear, prefetch_next, sleep_nop_done;
  logic resume_exec, vector_to_isr, timeout_flag, powerdown_flag, v;
  swc_power_s power_ctl, pc;
  int n_fail = 0, cmp_count = 0, n, n0;
  swc_row_s rows [12] = '{
    '{1'b0, SWC_OFF_FLAGS3, 32'h0, 32'h0, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_ENABLE3, 32'h0, 32'h0, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_REGCTL, 32'h0, 32'h1, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_STATUS, 32'h0, 32'h18, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_SLPCFG, 32'h0, 32'h0, SWC_RESP_OKAY},
    '{1'b1, SWC_OFF_FLAGS3, 32'hFFFF_FFFF, 32'h0, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_FLAGS3, 32'h0, 32'h3, SWC_RESP_OKAY},
    '{1'b1, SWC_OFF_FLAGS3, 32'h0, 32'h0, SWC_RESP_OKAY},
    '{1'b1, SWC_OFF_REGCTL, 32'h0, 32'h0, SWC_RESP_OKAY},
    '{1'b0, SWC_OFF_REGCTL, 32'h0, 32'h1, SWC_RESP_OKAY},
    '{1'b0, 8'h14, 32'h0, 32'h0, SWC_RESP_SLVERR},
    '{1'b1, 8'h14, 32'h5, 32'h0, SWC_RESP_SLVERR}};

  swc_sleep_wake #(.OST_CYCLES(OST), .REG_SETTLE_CYCLES(SET)) swc_sleep_wake_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .global_irq_enable,
    .ext_irq_pending, .logic_cell1_event, .logic_cell2_event, .lp_unfit_periph_en,
    .low_freq_tick, .watchdog_timeout, .external_reset_pin_n, .brownout_reset,
    .power_on_reset, .device_reset_req, .watchdog_clear, .prefetch_next,
    .sleep_nop_done, .resume_exec, .vector_to_isr, .power_ctl, .timeout_flag,
    .powerdown_flag);
  swc_core_model swc_core_model_inst (.aclk, .aresetn, .go, .resume_exec,
    .sleep_nop_done, .device_reset_req, .sleep_exec);

  always #2.5 aclk = ~aclk;

  // ==========================================
  // Bus and sequence tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    axi_wr(a, wd, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    axi_rd(a, d, r);
    `CHK(d, x)
  endtask : rdc

  task automatic sleep_cmd();
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : sleep_cmd

  // Sleep, then wake by cell interrupt or, after a disabled event, by watchdog
  task automatic nap(input bit by_wdt);
    sleep_cmd();
    repeat (6) @(posedge aclk);
    pc = power_ctl;
    rdc(SWC_OFF_STATUS, 32'h310);
    logic_cell1_event <= 1'b1;
    @(posedge aclk);
    logic_cell1_event <= 1'b0;
    low_freq_tick <= 1'b1;
    n = 0;
    if (by_wdt) begin
      repeat (20) begin
        @(posedge aclk);
        if (resume_exec !== 1'b0) n++;
      end
      `CHK(n, 0)
      watchdog_timeout <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (resume_exec !== 1'b1 && n < 2000);
    v = vector_to_isr;
    low_freq_tick <= 1'b0;
    watchdog_timeout <= 1'b0;
  endtask : nap

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, r);
      end else begin
        axi_rd(rows[i].a, d, r);
        `CHK(d, rows[i].x)
      end
      `CHK(r, rows[i].rsp)
    end
    @(posedge aclk);
    logic_cell2_event <= 1'b1;
    @(posedge aclk);
    logic_cell2_event <= 1'b0;
    rdc(SWC_OFF_FLAGS3, 32'h2);
    wr(SWC_OFF_FLAGS3, 32'h0);
    wr(SWC_OFF_ENABLE3, 32'h1);
    wr(SWC_OFF_FLAGS3, 32'h1);
    sleep_cmd();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sleep_nop_done !== 1'b1 && n < 20);
    `CHK(n < 20, 1'b1)
    rdc(SWC_OFF_STATUS, 32'h18);
    wr(SWC_OFF_FLAGS3, 32'h0);
    wr(SWC_OFF_SLPCFG, 32'h1E);
    global_irq_enable <= 1'b1;
    nap(1'b0);
    `CHK(pc, 8'b0111_1100)
    `CHK(v, 1'b1)
    `CHK(n < 2000, 1'b1)
    wr(SWC_OFF_FLAGS3, 32'h0);
    wr(SWC_OFF_ENABLE3, 32'h0);
    for (int m = 0; m < 6; m++) begin
      wr(SWC_OFF_SLPCFG, {21'h0, 3'(m), 8'h01});
      nap(1'b1);
      if (m == 0) n0 = n;
      `CHK(n - n0, (m >= 3) ? OST : 0)
      `CHK(v, 1'b0)
      `CHK(pc, 8'b0100_0101)
      rdc(SWC_OFF_STATUS, 32'h0);
    end
    wr(SWC_OFF_SLPCFG, 32'h1);
    wr(SWC_OFF_REGCTL, 32'h3);
    nap(1'b1);
    `CHK(pc, 8'b0100_0111)
    `CHK(n - n0, SET)
    lp_unfit_periph_en <= 1'b1;
    nap(1'b1);
    `CHK(pc, 8'b0100_0101)
    `CHK(n - n0, 0)
    lp_unfit_periph_en <= 1'b0;
    ext_irq_pending <= 8'h1;
    sleep_cmd();
    repeat (8) @(posedge aclk);
    `CHK({resume_exec, vector_to_isr, timeout_flag}, 3'b111)
    ext_irq_pending <= 8'h0;
    for (int k = 0; k < 3; k++) begin
      sleep_cmd();
      repeat (6) @(posedge aclk);
      external_reset_pin_n <= (k != 0);
      brownout_reset <= (k == 1);
      power_on_reset <= (k == 2);
      repeat (6) @(posedge aclk);
      `CHK(device_reset_req, 1'b1)
      external_reset_pin_n <= 1'b1;
      brownout_reset <= 1'b0;
      power_on_reset <= 1'b0;
      repeat (8) @(posedge aclk);
      `CHK(power_ctl.cpu_clk_en, 1'b1)
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(SWC_OFF_REGCTL, 32'h1);
    rdc(SWC_OFF_STATUS, 32'h18);
    complete_run();
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    complete_run();
  end
endmodule : swc_sleep_wake_test
`default_nettype wire
